// >>> rtl/ddsc_top.sv
// DDS core with programmable modulus and data source priority.
// Assumes a synchronous register write/read port and pins synchronous to clock.
//
// Behaviour
// - Modulus mode: ramp becomes wrapping auxiliary accumulator
// - Each wrap adds one phase LSB
// - Word, B, A at offsets 04, 05, 06
// - Modulus mode owns frequency exclusively
// - No ramp phase/amplitude sweep in modulus mode
// - Ramp next; unswept parameters from profile
// - Profiles below ramp, per parameter
// - Parallel port only when nothing higher enabled
// - Profile beats parallel port on frequency
// - Profile amplitude only with keying enabled
// - Control bit 16 picks sine or cosine
// - Frequency is word over 2^32 times clock
// - Upper half of words aliases
// - 16-bit phase offset before conversion
// - 12-bit amplitude scale after conversion
// - Parameters update at most one sixteenth rate
// - Internal modulation clock at one sixteenth rate
// - Profile select acts at next modulation tick
// - Ramp feeds 32, 16 or 12 bits
`timescale 1ns/1ps
`include "ddsc_map.svh"
module ddsc_top #(
	parameter int MOD_DIV = `DDSC_MOD_DIV,
	parameter int NPROF   = 8
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Register port
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	// Modulation inputs
	input  wire logic [2:0]  profile_select,
	input  wire logic [31:0] par_data,
	input  wire logic [3:0]  par_func,
	input  wire logic [31:0] ramp_value,
	// Outputs
	output logic             mod_tick,
	output logic      [11:0] dac_code
);
	// --------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------
	logic [31:0] ctrl1_q;
	logic [31:0] ctrl2_q;
	logic [31:0] ftw_q;
	logic [31:0] mod_b_q;
	logic [31:0] mod_a_q;
	logic [31:0] prof_freq_q [NPROF];
	logic [31:0] prof_pa_q   [NPROF];
	logic [31:0] rdata_q;
	logic [7:0]  prof_off;
	logic        prof_hit;

	assign prof_off = reg_addr - `DDSC_REG_PROF_BASE;
	assign prof_hit = reg_addr >= `DDSC_REG_PROF_BASE && reg_addr <= `DDSC_REG_PROF_LAST;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1_q <= `DDSC_CTRL_RESET;
			ctrl2_q <= `DDSC_CTRL_RESET;
			ftw_q   <= `DDSC_WORD_RESET;
			mod_b_q <= `DDSC_WORD_RESET;
			mod_a_q <= `DDSC_WORD_RESET;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`DDSC_REG_CTRL1: ctrl1_q <= reg_wdata;
				`DDSC_REG_CTRL2: ctrl2_q <= reg_wdata;
				`DDSC_REG_FTW:   ftw_q   <= reg_wdata;
				`DDSC_REG_MOD_B: mod_b_q <= reg_wdata;
				`DDSC_REG_MOD_A: mod_a_q <= reg_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NPROF; i++) begin
				prof_freq_q[i] <= `DDSC_WORD_RESET;
				prof_pa_q[i]   <= `DDSC_WORD_RESET;
			end
		end else if (reg_wr && prof_hit) begin
			if (prof_off[0]) begin
				prof_pa_q[prof_off[3:1]] <= reg_wdata;
			end else begin
				prof_freq_q[prof_off[3:1]] <= reg_wdata;
			end
		end
	end

	// --------------------------------------------------------------
	// Control decode
	// --------------------------------------------------------------
	logic                pm_en;
	logic                ramp_en;
	logic                prof_en;
	logic                par_en;
	logic                osk_en;
	ddsc_pkg::ddsc_dest_t ramp_dest;
	ddsc_pkg::ddsc_dest_t par_dest;

	assign pm_en     = ctrl2_q[`DDSC_PM_EN_BIT];
	assign ramp_en   = ctrl2_q[`DDSC_RAMP_EN_BIT];
	assign prof_en   = ctrl2_q[`DDSC_PROF_EN_BIT];
	assign par_en    = ctrl2_q[`DDSC_PAR_EN_BIT];
	assign osk_en    = ctrl1_q[`DDSC_OSK_BIT];
	assign ramp_dest = ddsc_pkg::ddsc_dest_t'(ctrl2_q[`DDSC_RAMP_DEST_HI:`DDSC_RAMP_DEST_LO]);
	assign par_dest  = ddsc_pkg::ddsc_dest_t'(par_func[1:0]);

	// --------------------------------------------------------------
	// Modulation clock
	// --------------------------------------------------------------
	localparam int CW = $clog2(MOD_DIV);
	localparam logic [CW-1:0] DIV_LAST = CW'(MOD_DIV - 1);
	logic [CW-1:0] div_q;
	logic          tick_q;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			div_q  <= (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
			tick_q <= (div_q == DIV_LAST);
		end
	end

	// --------------------------------------------------------------
	// Source priority
	// --------------------------------------------------------------
	logic [31:0] prof_freq;
	logic [15:0] prof_phase;
	logic [11:0] prof_amp;
	logic        ramp_f;
	logic        ramp_p;
	logic        ramp_a;
	logic        par_f;
	logic        par_p;
	logic        par_a;
	logic [31:0] freq_d;
	logic [15:0] phase_d;
	logic [11:0] amp_d;
	ddsc_pkg::ddsc_src_t src_d;

	// The select pins are read directly on the tick, so the new profile loads there.
	assign prof_freq  = prof_freq_q[profile_select];
	assign prof_phase = prof_pa_q[profile_select][15:0];
	assign prof_amp   = prof_pa_q[profile_select][27:16];

	// Ramp is consumed by the modulus accumulator in modulus mode.
	assign ramp_f = ramp_en && !pm_en && ramp_dest == ddsc_pkg::DDSC_DEST_FREQ;
	assign ramp_p = ramp_en && !pm_en && ramp_dest == ddsc_pkg::DDSC_DEST_PHASE;
	assign ramp_a = ramp_en && !pm_en && ramp_dest == ddsc_pkg::DDSC_DEST_AMP;
	assign par_f  = par_en && par_dest == ddsc_pkg::DDSC_DEST_FREQ;
	assign par_p  = par_en && (par_dest == ddsc_pkg::DDSC_DEST_PHASE
		|| par_dest == ddsc_pkg::DDSC_DEST_POLAR);
	assign par_a  = par_en && (par_dest == ddsc_pkg::DDSC_DEST_AMP
		|| par_dest == ddsc_pkg::DDSC_DEST_POLAR);

	always_comb begin
		if (pm_en) begin
			freq_d = ftw_q;
			src_d  = ddsc_pkg::DDSC_SRC_MODULUS;
		end else if (ramp_f) begin
			freq_d = ramp_value;
			src_d  = ddsc_pkg::DDSC_SRC_RAMP;
		end else if (par_f && !prof_en) begin
			freq_d = par_data;
			src_d  = ddsc_pkg::DDSC_SRC_PARALLEL;
		end else begin
			freq_d = prof_freq;
			src_d  = ddsc_pkg::DDSC_SRC_PROFILE;
		end
	end

	always_comb begin
		if (ramp_p) begin
			phase_d = ramp_value[15:0];
		end else if (par_p && !prof_en) begin
			phase_d = (par_dest == ddsc_pkg::DDSC_DEST_POLAR) ? par_data[31:16]
				: par_data[15:0];
		end else begin
			phase_d = prof_phase;
		end
	end

	always_comb begin
		if (!osk_en) begin
			amp_d = `DDSC_AMP_FULL;
		end else if (ramp_a) begin
			amp_d = ramp_value[11:0];
		end else if (par_a && !prof_en) begin
			amp_d = par_data[11:0];
		end else begin
			amp_d = prof_amp;
		end
	end

	// --------------------------------------------------------------
	// Parameter hold, updated only on modulation ticks
	// --------------------------------------------------------------
	logic [31:0]         freq_q;
	logic [15:0]         phase_q;
	logic [11:0]         amp_q;
	logic                cos_q;
	logic                pm_q;
	ddsc_pkg::ddsc_src_t src_q;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			freq_q  <= `DDSC_WORD_RESET;
			phase_q <= '0;
			amp_q   <= `DDSC_AMP_FULL;
			cos_q   <= 1'b1;
			pm_q    <= 1'b0;
			src_q   <= ddsc_pkg::DDSC_SRC_PROFILE;
		end else if (tick_q) begin
			freq_q  <= freq_d;
			phase_q <= phase_d;
			amp_q   <= amp_d;
			cos_q   <= !ctrl1_q[`DDSC_SINE_BIT];
			pm_q    <= pm_en;
			src_q   <= src_d;
		end
	end

	// --------------------------------------------------------------
	// Read back
	// --------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else if (reg_rd) begin
			if (prof_hit) begin
				rdata_q <= prof_off[0] ? prof_pa_q[prof_off[3:1]] : prof_freq_q[prof_off[3:1]];
			end else begin
				unique case (reg_addr)
					`DDSC_REG_CTRL1:  rdata_q <= ctrl1_q;
					`DDSC_REG_CTRL2:  rdata_q <= ctrl2_q;
					`DDSC_REG_FTW:    rdata_q <= ftw_q;
					`DDSC_REG_MOD_B:  rdata_q <= mod_b_q;
					`DDSC_REG_MOD_A:  rdata_q <= mod_a_q;
					`DDSC_REG_STATUS: rdata_q <= {30'h0, src_q};
					default:          rdata_q <= '0;
				endcase
			end
		end
	end

	// --------------------------------------------------------------
	// Datapath
	// --------------------------------------------------------------
	ddsc_param_if prm ();

	assign prm.freq   = freq_q;
	assign prm.phase  = phase_q;
	assign prm.amp    = amp_q;
	assign prm.cosine = cos_q;

	ddsc_aux_acc #(
		.W(32)
	) u_aux (
		.clock       (clock),
		.rst_n       (rst_n),
		.enable      (pm_q),
		.numerator   (mod_a_q),
		.denominator (mod_b_q),
		.prm         (prm.aux)
	);

	ddsc_nco u_nco (
		.clock    (clock),
		.rst_n    (rst_n),
		.prm      (prm.core),
		.dac_code (dac_code)
	);

	assign reg_rdata = rdata_q;
	assign mod_tick  = tick_q;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	a_tick_period: assert property (@(posedge clock) disable iff (!rst_n)
		tick_q |=> !tick_q [*8] ##0 (div_q == 4'(8)))
		else $error("Modulation tick spacing wrong.");
	a_param_gated: assert property (@(posedge clock) disable iff (!rst_n)
		!tick_q |=> $stable(freq_q) && $stable(phase_q) && $stable(amp_q))
		else $error("Parameter changed off the modulation tick.");
	a_modulus_freq: assert property (@(posedge clock) disable iff (!rst_n)
		tick_q && pm_en |=> freq_q == $past(ftw_q))
		else $error("Modulus mode lost the frequency word.");
	a_modulus_ramp: assert property (@(posedge clock) disable iff (!rst_n)
		tick_q && pm_en && !(par_p && !prof_en) |=> phase_q == $past(prof_phase))
		else $error("Ramp swept phase in modulus mode.");
	a_prof_over_par: assert property (@(posedge clock) disable iff (!rst_n)
		tick_q && !pm_en && !ramp_f && prof_en |=> freq_q == $past(prof_freq))
		else $error("Profile lost frequency to parallel port.");
	a_par_freq: assert property (@(posedge clock) disable iff (!rst_n)
		tick_q && !pm_en && !ramp_f && !prof_en && par_f |=> freq_q == $past(par_data))
		else $error("Parallel port frequency not applied.");
	a_amp_keying: assert property (@(posedge clock) disable iff (!rst_n)
		tick_q && !osk_en |=> amp_q == `DDSC_AMP_FULL)
		else $error("Amplitude applied without keying enable.");
	a_ramp_freq: assert property (@(posedge clock) disable iff (!rst_n)
		tick_q && ramp_f |=> freq_q == $past(ramp_value) && src_q == ddsc_pkg::DDSC_SRC_RAMP)
		else $error("Ramp frequency not applied.");
endmodule

// >>> pkg/ddsc_map.svh
// Register offsets, field positions, reset values and fixed counts of the DDS core.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef DDSC_MAP_SVH
`define DDSC_MAP_SVH

`define DDSC_REG_CTRL1     8'h00
`define DDSC_REG_CTRL2     8'h01
`define DDSC_REG_FTW       8'h04
`define DDSC_REG_MOD_B     8'h05
`define DDSC_REG_MOD_A     8'h06
`define DDSC_REG_PROF_BASE 8'h0b
`define DDSC_REG_PROF_LAST 8'h1a
`define DDSC_REG_STATUS    8'h1c

`define DDSC_SINE_BIT      16
`define DDSC_OSK_BIT       8
`define DDSC_PROF_EN_BIT   23
`define DDSC_PAR_EN_BIT    22
`define DDSC_RAMP_DEST_HI  21
`define DDSC_RAMP_DEST_LO  20
`define DDSC_RAMP_EN_BIT   19
`define DDSC_PM_EN_BIT     16

`define DDSC_CTRL_RESET    32'h0000_0000
`define DDSC_WORD_RESET    32'h0000_0000
`define DDSC_AMP_FULL      12'hfff
`define DDSC_QUARTER_TURN  16'h4000
`define DDSC_MID_CODE      12'h800
`define DDSC_SINE_PEAK     12'h7ff
`define DDSC_MOD_DIV       16

`endif

// >>> pkg/ddsc_pkg.sv
// Types shared by the DDS core modules.
// Assumes nothing of its surroundings.
package ddsc_pkg;
	// Destination of the ramp generator or of a parallel port word.
	typedef enum logic [1:0] {
		DDSC_DEST_AMP,
		DDSC_DEST_PHASE,
		DDSC_DEST_FREQ,
		DDSC_DEST_POLAR
	} ddsc_dest_t;

	// Source that currently owns the frequency parameter.
	typedef enum logic [1:0] {
		DDSC_SRC_MODULUS,
		DDSC_SRC_RAMP,
		DDSC_SRC_PROFILE,
		DDSC_SRC_PARALLEL
	} ddsc_src_t;
endpackage

// >>> pkg/ddsc_param_if.sv
// Signal control parameters passed from the source selector to the DDS core.
// Assumes one instance per core, all ends on the sample clock.
`timescale 1ns/1ps
interface ddsc_param_if;
	logic [31:0] freq;
	logic [15:0] phase;
	logic [11:0] amp;
	logic        cosine;
	logic        carry;

	modport sel  (output freq, output phase, output amp, output cosine);
	modport aux  (output carry);
	modport core (input freq, input phase, input amp, input cosine, input carry);
endinterface

// >>> rtl/ddsc_aux_acc.sv
// Auxiliary accumulator for programmable modulus mode.
// Assumes the caller keeps the numerator below the denominator and the denominator at least 2.
`timescale 1ns/1ps
`include "ddsc_map.svh"
module ddsc_aux_acc #(
	parameter int W = 32
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         rst_n,
	// Control
	input  wire logic         enable,
	input  wire logic [W-1:0] numerator,
	input  wire logic [W-1:0] denominator,
	// Carry into the phase accumulator
	ddsc_param_if.aux         prm
);
	logic [W-1:0] acc_q;
	logic         carry_q;
	logic [W:0]   sum;

	assign sum = {1'b0, acc_q} + {1'b0, numerator};

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			acc_q   <= '0;
			carry_q <= 1'b0;
		end else if (!enable) begin
			acc_q   <= '0;
			carry_q <= 1'b0;
		end else if (sum >= {1'b0, denominator}) begin
			acc_q   <= W'(sum - {1'b0, denominator});
			carry_q <= 1'b1;
		end else begin
			acc_q   <= sum[W-1:0];
			carry_q <= 1'b0;
		end
	end

	assign prm.carry = carry_q;

	a_aux_carry_set: assert property (@(posedge clock) disable iff (!rst_n)
		enable && sum >= {1'b0, denominator} |=> carry_q && acc_q < $past(denominator))
		else $error("Auxiliary accumulator missed its wrap.");
	a_aux_no_carry: assert property (@(posedge clock) disable iff (!rst_n)
		!enable |=> !carry_q && acc_q == '0)
		else $error("Auxiliary accumulator ran outside modulus mode.");
endmodule

// >>> rtl/ddsc_nco.sv
// Phase accumulator, phase offset, angle to amplitude conversion and amplitude scaling.
// Assumes parameters change only on modulation clock ticks.
`timescale 1ns/1ps
`include "ddsc_map.svh"
module ddsc_nco (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Parameters and modulus carry
	ddsc_param_if.core       prm,
	// Sample output, offset binary
	output logic      [11:0] dac_code
);
	logic [31:0] acc_q;
	logic [15:0] angle;
	logic [14:0] pos;
	logic [29:0] bow;
	logic [11:0] mag;
	logic signed [12:0] samp_q;
	logic signed [25:0] scaled;
	logic [11:0] dac_q;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= '0;
		end else begin
			acc_q <= acc_q + prm.freq + {31'h0, prm.carry};
		end
	end

	// Parabolic half-cycle shape; cosine is a quarter turn ahead.
	assign angle = acc_q[31:16] + prm.phase + (prm.cosine ? `DDSC_QUARTER_TURN : 16'h0000);
	assign pos   = angle[14:0];
	assign bow   = 30'({15'h0, pos} * (30'h0000_8000 - {15'h0, pos}));
	assign mag   = (bow[29:17] > 13'(`DDSC_SINE_PEAK)) ? `DDSC_SINE_PEAK : bow[28:17];
	assign scaled = samp_q * $signed({1'b0, prm.amp});

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			samp_q <= '0;
			dac_q  <= `DDSC_MID_CODE;
		end else begin
			samp_q <= angle[15] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
			dac_q  <= 12'(scaled[24:12]) + `DDSC_MID_CODE;
		end
	end

	assign dac_code = dac_q;

	a_phase_step: assert property (@(posedge clock) disable iff (!rst_n)
		##1 acc_q == 32'($past(acc_q) + $past(prm.freq) + {31'h0, $past(prm.carry)}))
		else $error("Phase accumulator step wrong.");
endmodule

// >>> bench/dds_core_modulus_priority_tb.sv
// Self-checking bench for the DDS core: register port, source priority and sample output.
// Assumes the core top, its package, interface and map header are compiled before it.
`timescale 1ns/1ps
module dds_core_modulus_priority_tb;
	// ----------------------------------------
	// Signals and rows
	// ----------------------------------------
	typedef struct {
		logic [31:0] c1;
		logic [31:0] c2;
		logic [3:0]  fn;
		logic [31:0] pd;
		logic [31:0] rv;
		logic [1:0]  src;
		logic [11:0] dac;
	} ddsc_row_t;

	logic        clock          = 1'b0;
	logic        rst_n          = 1'b0;
	logic        reg_wr         = 1'b0;
	logic        reg_rd         = 1'b0;
	logic [7:0]  reg_addr       = 8'h00;
	logic [31:0] reg_wdata      = 32'h0;
	logic [31:0] reg_rdata;
	logic [2:0]  profile_select = 3'h0;
	logic [31:0] par_data       = 32'h0;
	logic [3:0]  par_func       = 4'h0;
	logic [31:0] ramp_value     = 32'h0;
	logic        mod_tick;
	logic [11:0] dac_code;
	int          n_errors       = 0;
	int          checks         = 0;

	// Frequency stays zero in every row, so each row settles to one steady sample.
	ddsc_row_t rows [18] = '{
		'{32'h0, 32'h0, 4'h0, 32'h0, 32'h0, 2'h2, 12'hffe},
		'{32'h1_0000, 32'h0, 4'h0, 32'h0, 32'h0, 2'h2, 12'h800},
		'{32'h100, 32'h0, 4'h0, 32'h0, 32'h0, 2'h2, 12'h800},
		'{32'h1_0000, 32'h18_0000, 4'h0, 32'h0, 32'h1_4000, 2'h2, 12'hffe},
		'{32'h1_0000, 32'h19_0000, 4'h0, 32'h0, 32'h4000, 2'h0, 12'h800},
		'{32'h100, 32'h08_0000, 4'h0, 32'h0, 32'h1234_5800, 2'h2, 12'hbff},
		'{32'h1_0000, 32'h40_0000, 4'h1, 32'h4000, 32'h0, 2'h2, 12'hffe},
		'{32'h1_0000, 32'hc0_0000, 4'h1, 32'h4000, 32'h0, 2'h2, 12'h800},
		'{32'h1_0100, 32'h40_0000, 4'h3, 32'h4000_0800, 32'h0, 2'h2, 12'hbff},
		'{32'h100, 32'h40_0000, 4'h0, 32'h800, 32'h0, 2'h2, 12'hbff},
		'{32'h1_0000, 32'h58_0000, 4'h1, 32'h0, 32'h4000, 2'h2, 12'hffe},
		'{32'h0, 32'h01_0000, 4'h0, 32'h0, 32'h0, 2'h0, 12'hffe},
		'{32'h0, 32'h28_0000, 4'h0, 32'h0, 32'h0, 2'h1, 12'hffe},
		'{32'h0, 32'h29_0000, 4'h0, 32'h0, 32'h0, 2'h0, 12'hffe},
		'{32'h0, 32'h40_0000, 4'h2, 32'h0, 32'h0, 2'h3, 12'hffe},
		'{32'h0, 32'hc0_0000, 4'h2, 32'h0, 32'h0, 2'h2, 12'hffe},
		'{32'h0, 32'h68_0000, 4'h2, 32'h0, 32'h0, 2'h1, 12'hffe},
		'{32'h0, 32'h41_0000, 4'h2, 32'h0, 32'h0, 2'h0, 12'hffe}
	};

	always #20 clock = ~clock;

	ddsc_top #(.MOD_DIV(16), .NPROF(8)) ddsc_top_inst (
		.clock          (clock),
		.rst_n          (rst_n),
		.reg_wr         (reg_wr),
		.reg_rd         (reg_rd),
		.reg_addr       (reg_addr),
		.reg_wdata      (reg_wdata),
		.reg_rdata      (reg_rdata),
		.profile_select (profile_select),
		.par_data       (par_data),
		.par_func       (par_func),
		.ramp_value     (ramp_value),
		.mod_tick       (mod_tick),
		.dac_code       (dac_code)
	);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_dac(input string what, input logic [11:0] exp, input logic [11:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(negedge clock);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clock);
		reg_wr = 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(negedge clock);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clock);
		reg_rd = 1'b0;
		@(negedge clock);
		d = reg_rdata;
	endtask

	// Counts falling edges until the modulation tick is seen high.
	task automatic wait_tick(output int k);
		k = 0;
		do begin
			@(negedge clock);
			k++;
		end while (mod_tick !== 1'b1 && k < 40);
	endtask

	// Two ticks make sure fresh register values were sampled, then the pipeline drains.
	task automatic settle;
		int k;
		wait_tick(k);
		wait_tick(k);
		repeat (4) @(negedge clock);
	endtask

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		chk_word("run time limit", 32'h0, 32'h1);
		tally_and_finish();
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		int          k;
		int          n8;
		int          nf;
		logic [31:0] d;
		logic [11:0] s [20];
		repeat (12) @(negedge clock);
		chk_word("reset read data", 32'h0, reg_rdata);
		chk_word("reset tick", 32'h0, {31'h0, mod_tick});
		chk_dac("reset sample", 12'h800, dac_code);
		rst_n = 1'b1;
		wait_tick(k);
		chk_word("first tick", 32'h10, 32'(k));
		wait_tick(k);
		chk_word("tick period", 32'h10, 32'(k));
		for (int i = 0; i < 3; i++) begin
			rd_reg(8'h04 + 8'(i), d);
			chk_word("word reset", 32'h0, d);
			wr_reg(8'h04 + 8'(i), 32'hc3a5_0f96 ^ 32'(i));
			rd_reg(8'h04 + 8'(i), d);
			chk_word("word readback", 32'hc3a5_0f96 ^ 32'(i), d);
		end
		wr_reg(8'h03, 32'hffff_ffff);
		rd_reg(8'h03, d);
		chk_word("unmapped read", 32'h0, d);
		wr_reg(8'h04, 32'h0);
		wr_reg(8'h05, 32'h5);
		wr_reg(8'h06, 32'h0);
		for (int i = 0; i < 18; i++) begin
			wr_reg(8'h00, rows[i].c1);
			wr_reg(8'h01, rows[i].c2);
			par_func = rows[i].fn;
			par_data = rows[i].pd;
			ramp_value = rows[i].rv;
			settle();
			chk_dac("row sample", rows[i].dac, dac_code);
			rd_reg(8'h1c, d);
			chk_word("freq source", {30'h0, rows[i].src}, {30'h0, d[1:0]});
		end
		// Profile select must wait for the next tick.
		wr_reg(8'h00, 32'h1_0000);
		wr_reg(8'h01, 32'h0);
		wr_reg(8'h12, 32'h0fff_4000);
		rd_reg(8'h12, d);
		chk_word("profile word readback", 32'h0fff_4000, d);
		par_func = 4'h0;
		par_data = 32'h0;
		ramp_value = 32'h0;
		settle();
		wait_tick(k);
		@(negedge clock);
		profile_select = 3'h3;
		for (int i = 0; i < 12; i++) begin
			@(negedge clock);
			chk_dac("held profile", 12'h800, dac_code);
		end
		wait_tick(k);
		repeat (4) @(negedge clock);
		chk_dac("new profile", 12'hffe, dac_code);
		// Quarter-turn tuning word gives a four-sample period; its alias looks the same.
		wr_reg(8'h12, 32'h0fff_0000);
		for (int j = 0; j < 2; j++) begin
			wr_reg(8'h11, (j != 0) ? 32'hc000_0000 : 32'h4000_0000);
			rd_reg(8'h11, d);
			chk_word("profile freq readback", (j != 0) ? 32'hc000_0000 : 32'h4000_0000, d);
			settle();
			n8 = 0;
			nf = 0;
			for (int i = 0; i < 8; i++) begin
				@(negedge clock);
				n8 += int'(dac_code === 12'h800);
				nf += int'(dac_code === 12'hffe);
			end
			chk_word("zero samples", 32'h4, 32'(n8));
			chk_word("peak samples", 32'h2, 32'(nf));
		end
		// Exact three tenths of the clock repeats every ten samples.
		wr_reg(8'h04, 32'h4ccc_cccc);
		wr_reg(8'h06, 32'h4);
		wr_reg(8'h01, 32'h1_0000);
		settle();
		n8 = 0;
		for (int i = 0; i < 20; i++) begin
			@(negedge clock);
			s[i] = dac_code;
			n8 += int'(dac_code === 12'h800);
		end
		for (int i = 0; i < 10; i++) begin
			chk_dac("modulus period", s[i], s[i + 10]);
		end
		chk_word("modulus moves", 32'h1, {31'h0, n8 < 20});
		// Second reset in mid-run.
		@(negedge clock);
		rst_n = 1'b0;
		@(negedge clock);
		chk_dac("mid reset sample", 12'h800, dac_code);
		chk_word("mid reset tick", 32'h0, {31'h0, mod_tick});
		rst_n = 1'b1;
		rd_reg(8'h04, d);
		chk_word("word after reset", 32'h0, d);
		tally_and_finish();
	end
endmodule
